// ### design/csric_pkg.sv
// Package with constants and types of the calibration, sync, reset and interrupt clear registers.
package csric_pkg;
	// Register indices; the byte address of each register is four times its index.
	localparam logic [13:0] IDX_TRANSFER  = 14'h0005;
	localparam logic [13:0] IDX_CAL_SYNC  = 14'h0A02;
	localparam logic [13:0] IDX_RESET_FN  = 14'h0A03;
	localparam logic [13:0] IDX_IRQ_CLEAR = 14'h0A04;
	localparam logic [13:0] IDX_STATUS    = 14'h0F00;
	localparam logic [13:0] IDX_IRQ_FLAGS = 14'h0F01;
	localparam logic [13:0] IDX_TUNING    = 14'h0F02;

	// Field positions in the calibration and sync control register.
	localparam int CS_CAL_BIT  = 0;
	localparam int CS_SYNC_BIT = 1;
	localparam logic [7:0] CS_MASK = 8'h03;

	// Field positions in the transfer register.
	localparam int TRANSFER_BIT = 0;

	// Field positions in the reset functions register.
	localparam int RF_WATCHDOG_BIT    = 0;
	localparam int RF_ALL_IRQ_BIT     = 1;
	localparam int RF_TW_HISTORY_BIT  = 2;
	localparam int RF_AUTO_SYNC_BIT   = 3;
	localparam int RF_PHASE_ACC_BIT   = 4;
	localparam int RF_COMB_FILTER_BIT = 5;
	localparam int RF_LOOP_FILTER_BIT = 6;
	localparam logic [7:0] RF_MASK = 8'h7F;

	// Field positions in the system clock interrupt clear byte and its flags.
	localparam int IRQ_CAL_START_BIT = 0;
	localparam int IRQ_CAL_DONE_BIT  = 1;
	localparam int IRQ_LOCKED_BIT    = 4;
	localparam int IRQ_UNLOCKED_BIT  = 5;
	localparam logic [7:0] IRQ_MASK = 8'h33;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Calibration timing; the whole routine lasts this long.
	localparam int unsigned CLK_MHZ     = 50;
	localparam int unsigned CAL_TIME_US = 2000;
	localparam int unsigned CAL_CYCLES  = CAL_TIME_US * CLK_MHZ;
	localparam logic [3:0]  BAND_MAX    = 4'hF;
	localparam logic [2:0]  AMP_MAX     = 3'h7;

	// Calibration sequence states.
	typedef enum logic [1:0] {
		CAL_IDLE   = 2'b00,
		CAL_BAND   = 2'b01,
		CAL_AMP    = 2'b10,
		CAL_SETTLE = 2'b11
	} csric_cal_state_type;

	// Signals that the bus master drives.
	typedef struct packed {
		logic        awvalid;
		logic [15:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [15:0] araddr;
		logic        rready;
	} csric_axi_req_type;

	// Signals that the slave drives back.
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} csric_axi_rsp_type;

	// All state of the register block.
	typedef struct packed {
		logic                aw_held;
		logic [15:0]         aw_addr;
		logic                w_held;
		logic [7:0]          w_data;
		logic                w_strb0;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [7:0]          rdata;
		logic [1:0]          rresp;
		logic [1:0]          cs_buffer;
		logic [1:0]          cs_active;
		logic                dist_sync_pulse;
		logic [7:0]          rf_pulse;
		logic [7:0]          irq_flags;
		csric_cal_state_type cal_state;
		logic [31:0]         cal_count;
		logic [3:0]          vco_band;
		logic [2:0]          vco_amp;
		logic                cal_start_ev;
		logic                cal_done_ev;
		logic                lock_meta;
		logic                lock_sync;
		logic                lock_prev;
		logic [31:0]         wdog_count;
		logic                wdog_timeout;
	} csric_state_type;

	// Every field starts at zero, with the calibration sequence idle.
	localparam csric_state_type STATE_RESET = '0;
endpackage

// ### design/csric_regs.sv
// Calibration, distribution sync, reset function and interrupt clear registers on AXI4-Lite.
// Overview of operation
// - Sync bit high stalls distribution outputs.
// - Sync bit falling resynchronizes distribution outputs.
// - Committed calibrate rise starts enabled PLL calibration.
// - Calibration picks band and amplitude itself.
// - System clock halted while calibration runs.
// - Calibrate and sync bits reset to zero.
// - Reset bit 6 clears loop filter.
// - Reset bit 5 clears comb integrator filter.
// - Reset bit 4 zeroes phase accumulator.
// - Reset bit 3 resets automatic output sync.
// - Reset bit 2 reinitializes tuning word history.
// - Reset bit 1 clears all interrupt flags.
// - Watchdog reset restarts count, no timeout.
// - Reset function bits clear themselves.
// - Clear bit resets its interrupt flag.
// - Clear layout matches interrupt monitor layout.
// - Interrupt clear bits return to zero.
// - Clear bits 5,4,1,0: unlock, lock, done, start.
module csric_regs #(
	parameter int unsigned CAL_CYCLES = csric_pkg::CAL_CYCLES
) (
	// Clock and synchronous active low reset.
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// AXI4-Lite register bus.
	input  wire csric_pkg::csric_axi_req_type s_axi_req,
	output csric_pkg::csric_axi_rsp_type      s_axi_rsp,
	// System clock PLL interface.
	input  wire logic                         pll_enable,
	input  wire logic                         band_ok,
	input  wire logic                         amp_ok,
	input  wire logic                         pll_locked_pin,
	output logic                              system_clock_halt,
	output logic [3:0]                        vco_band,
	output logic [2:0]                        vco_amp,
	// Clock distribution control.
	output logic                              dist_stall,
	output logic                              dist_sync_pulse,
	// One cycle commands to the datapath.
	output logic                              clear_loop_filter,
	output logic                              clear_comb_integrator_filter,
	output logic                              clear_phase_accumulator,
	output logic                              reset_auto_sync,
	output logic                              reset_tuning_word_history,
	output logic                              clear_all_irqs,
	// Watchdog.
	input  wire logic [31:0]                  wdog_period,
	output logic                              watchdog_timeout,
	// System clock interrupt monitor flags.
	output logic [7:0]                        system_clock_irq_flags
);
	// Current and next state of the whole block.
	csric_pkg::csric_state_type s;
	csric_pkg::csric_state_type next_s;

	// Helper terms computed alongside the next state.
	logic       wr_fire;   // Both write halves are held and no response is pending.
	logic       wr_en;     // A write that carries the low byte lane.
	logic       rd_fire;   // A read address is taken this cycle.
	logic       commit;    // A transfer strobe is written this cycle.
	logic       cal_rise;  // The committed calibrate bit rises this cycle.
	logic       lock_rise; // The synchronised lock level rises.
	logic       lock_fall; // The synchronised lock level falls.
	logic [7:0] set_ev;    // Interrupt events arriving this cycle.
	logic [7:0] clr_ev;    // Interrupt clears requested this cycle.
	logic [7:0] rd_byte;   // Byte selected by the read address.

	// True when a byte address hits the given register index.
	function automatic logic is_reg(input logic [15:0] a, input logic [13:0] idx);
		return a == {idx, 2'b00};
	endfunction

	// True when a byte address hits any register of the block.
	function automatic logic is_mapped(input logic [15:0] a);
		return is_reg(a, csric_pkg::IDX_TRANSFER) || is_reg(a, csric_pkg::IDX_CAL_SYNC) ||
			is_reg(a, csric_pkg::IDX_RESET_FN) || is_reg(a, csric_pkg::IDX_IRQ_CLEAR) ||
			is_reg(a, csric_pkg::IDX_STATUS) || is_reg(a, csric_pkg::IDX_IRQ_FLAGS) ||
			is_reg(a, csric_pkg::IDX_TUNING);
	endfunction

	// Next state of the bus slave, the registers, calibration and watchdog.
	always_comb begin
		next_s = s;
		// One cycle pulses fall back to zero unless set below.
		next_s.dist_sync_pulse = 1'b0;
		next_s.rf_pulse = 8'h00;
		next_s.cal_start_ev = 1'b0;
		next_s.cal_done_ev = 1'b0;
		next_s.wdog_timeout = 1'b0;

		wr_fire = s.aw_held && s.w_held && !s.bvalid;
		wr_en = wr_fire && s.w_strb0;
		rd_fire = s_axi_req.arvalid && !s.rvalid;
		commit = wr_en && is_reg(s.aw_addr, csric_pkg::IDX_TRANSFER) &&
			s.w_data[csric_pkg::TRANSFER_BIT];
		cal_rise = commit && !s.cs_active[csric_pkg::CS_CAL_BIT] &&
			s.cs_buffer[csric_pkg::CS_CAL_BIT];
		lock_rise = s.lock_sync && !s.lock_prev;
		lock_fall = !s.lock_sync && s.lock_prev;

		// Write address and write data are taken in either order.
		if (s_axi_req.awvalid && !s.aw_held && !s.bvalid) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && !s.w_held && !s.bvalid) begin
			next_s.w_held = 1'b1;
			next_s.w_data = s_axi_req.wdata[7:0];
			next_s.w_strb0 = s_axi_req.wstrb[0];
		end
		// Once both halves are held the write acts and the response is raised.
		if (wr_fire) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = is_mapped(s.aw_addr) ? csric_pkg::RESP_OKAY : csric_pkg::RESP_DECERR;
		end
		if (s.bvalid && s_axi_req.bready) begin
			next_s.bvalid = 1'b0;
		end

		// Calibrate and sync bits are buffered until the transfer strobe.
		if (wr_en && is_reg(s.aw_addr, csric_pkg::IDX_CAL_SYNC)) begin
			next_s.cs_buffer = s.w_data[1:0];
		end
		if (commit) begin
			next_s.cs_active = s.cs_buffer;
			// A falling sync bit fires the resynchronization pulse.
			if (s.cs_active[csric_pkg::CS_SYNC_BIT] && !s.cs_buffer[csric_pkg::CS_SYNC_BIT]) begin
				next_s.dist_sync_pulse = 1'b1;
			end
		end

		// Reset function bits act once and are never stored.
		if (wr_en && is_reg(s.aw_addr, csric_pkg::IDX_RESET_FN)) begin
			next_s.rf_pulse = s.w_data & csric_pkg::RF_MASK;
		end

		// Interrupt flags: events set them, clear bits or a reset-all clear them.
		set_ev = 8'h00;
		set_ev[csric_pkg::IRQ_CAL_START_BIT] = s.cal_start_ev;
		set_ev[csric_pkg::IRQ_CAL_DONE_BIT] = s.cal_done_ev;
		set_ev[csric_pkg::IRQ_LOCKED_BIT] = lock_rise;
		set_ev[csric_pkg::IRQ_UNLOCKED_BIT] = lock_fall;
		clr_ev = 8'h00;
		if (wr_en && is_reg(s.aw_addr, csric_pkg::IDX_IRQ_CLEAR)) begin
			clr_ev = s.w_data & csric_pkg::IRQ_MASK;
		end
		if (s.rf_pulse[csric_pkg::RF_ALL_IRQ_BIT]) begin
			clr_ev = csric_pkg::IRQ_MASK;
		end
		// A set arriving with its clear wins, so no event is lost.
		next_s.irq_flags = (s.irq_flags & ~clr_ev) | set_ev;

		// Lock level from the analog PLL passes two flip-flops first.
		next_s.lock_meta = pll_locked_pin;
		next_s.lock_sync = s.lock_meta;
		next_s.lock_prev = s.lock_sync;

		// Calibration sequence: band search, amplitude search, then settle.
		unique case (s.cal_state)
			csric_pkg::CAL_IDLE: begin
				if (cal_rise && pll_enable) begin
					next_s.cal_state = csric_pkg::CAL_BAND;
					next_s.cal_count = 32'h0000_0000;
					next_s.vco_band = 4'h0;
					next_s.vco_amp = 3'h0;
					next_s.cal_start_ev = 1'b1;
				end
			end
			csric_pkg::CAL_BAND: begin
				next_s.cal_count = s.cal_count + 32'h0000_0001;
				// The first band that the comparator accepts is kept.
				if (band_ok || s.vco_band == csric_pkg::BAND_MAX) begin
					next_s.cal_state = csric_pkg::CAL_AMP;
				end else begin
					next_s.vco_band = s.vco_band + 4'h1;
				end
			end
			csric_pkg::CAL_AMP: begin
				next_s.cal_count = s.cal_count + 32'h0000_0001;
				// Amplitude rises until the level detector is satisfied.
				if (amp_ok || s.vco_amp == csric_pkg::AMP_MAX) begin
					next_s.cal_state = csric_pkg::CAL_SETTLE;
				end else begin
					next_s.vco_amp = s.vco_amp + 3'h1;
				end
			end
			csric_pkg::CAL_SETTLE: begin
				// The routine ends only after its full duration.
				if (s.cal_count >= 32'(CAL_CYCLES - 1)) begin
					next_s.cal_state = csric_pkg::CAL_IDLE;
					next_s.cal_done_ev = 1'b1;
				end else begin
					next_s.cal_count = s.cal_count + 32'h0000_0001;
				end
			end
		endcase

		// Watchdog: a reset request restarts without a timeout; period zero disables it.
		if (s.rf_pulse[csric_pkg::RF_WATCHDOG_BIT]) begin
			next_s.wdog_count = 32'h0000_0000;
		end else if (wdog_period != 32'h0000_0000) begin
			if (s.wdog_count >= wdog_period - 32'h0000_0001) begin
				next_s.wdog_timeout = 1'b1;
				next_s.wdog_count = 32'h0000_0000;
			end else begin
				next_s.wdog_count = s.wdog_count + 32'h0000_0001;
			end
		end

		// Read data; command and clear registers always read zero.
		rd_byte = 8'h00;
		if (is_reg(s_axi_req.araddr, csric_pkg::IDX_CAL_SYNC)) begin
			rd_byte = {6'h00, s.cs_buffer};
		end else if (is_reg(s_axi_req.araddr, csric_pkg::IDX_STATUS)) begin
			rd_byte = {5'h00, s.lock_sync, s.cs_active[csric_pkg::CS_SYNC_BIT],
				s.cal_state != csric_pkg::CAL_IDLE};
		end else if (is_reg(s_axi_req.araddr, csric_pkg::IDX_IRQ_FLAGS)) begin
			rd_byte = s.irq_flags;
		end else if (is_reg(s_axi_req.araddr, csric_pkg::IDX_TUNING)) begin
			rd_byte = {1'b0, s.vco_amp, s.vco_band};
		end
		if (s.rvalid && s_axi_req.rready) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_byte;
			next_s.rresp = is_mapped(s_axi_req.araddr) ? csric_pkg::RESP_OKAY :
				csric_pkg::RESP_DECERR;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= csric_pkg::STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Bus outputs: readies are combinational, data and responses come from flip-flops.
	assign s_axi_rsp.awready = !s.aw_held && !s.bvalid;
	assign s_axi_rsp.wready  = !s.w_held && !s.bvalid;
	assign s_axi_rsp.bvalid  = s.bvalid;
	assign s_axi_rsp.bresp   = s.bresp;
	assign s_axi_rsp.arready = !s.rvalid;
	assign s_axi_rsp.rvalid  = s.rvalid;
	assign s_axi_rsp.rdata   = {24'h00_0000, s.rdata};
	assign s_axi_rsp.rresp   = s.rresp;

	// Block outputs.
	assign system_clock_halt = s.cal_state != csric_pkg::CAL_IDLE;
	assign vco_band = s.vco_band;
	assign vco_amp = s.vco_amp;
	assign dist_stall = s.cs_active[csric_pkg::CS_SYNC_BIT];
	assign dist_sync_pulse = s.dist_sync_pulse;
	assign clear_loop_filter = s.rf_pulse[csric_pkg::RF_LOOP_FILTER_BIT];
	assign clear_comb_integrator_filter = s.rf_pulse[csric_pkg::RF_COMB_FILTER_BIT];
	assign clear_phase_accumulator = s.rf_pulse[csric_pkg::RF_PHASE_ACC_BIT];
	assign reset_auto_sync = s.rf_pulse[csric_pkg::RF_AUTO_SYNC_BIT];
	assign reset_tuning_word_history = s.rf_pulse[csric_pkg::RF_TW_HISTORY_BIT];
	assign clear_all_irqs = s.rf_pulse[csric_pkg::RF_ALL_IRQ_BIT];
	assign watchdog_timeout = s.wdog_timeout;
	assign system_clock_irq_flags = s.irq_flags;

	// A reset function write followed by its pulse and then silence.
	sequence s_rf_write;
		wr_en && is_reg(s.aw_addr, csric_pkg::IDX_RESET_FN);
	endsequence
	sequence s_rf_one_shot(logic [7:0] d);
		(s.rf_pulse == d) ##1 (s.rf_pulse == 8'h00);
	endsequence

	// A calibration start event followed by its sticky flag.
	sequence s_cal_started;
		s.cal_start_ev ##1 s.irq_flags[csric_pkg::IRQ_CAL_START_BIT];
	endsequence

	// A committed sync bit stalls the distribution outputs next cycle.
	a_stall_on_commit: assert property (@(posedge clk) disable iff (!rst_n)
		commit && s.cs_buffer[csric_pkg::CS_SYNC_BIT] |=> dist_stall)
		else $error("Distribution not stalled after sync commit.");

	// Resynchronization pulse comes exactly when the stall ends.
	a_sync_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(dist_stall) |-> dist_sync_pulse)
		else $error("No sync pulse when the stall ended.");

	// Calibration starts only from a committed rise with the PLL enabled.
	a_cal_launch: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(system_clock_halt) |-> $past(cal_rise) && $past(pll_enable))
		else $error("Calibration started without an enabled committed rise.");

	// Band search steps by one while the comparator rejects the band.
	a_band_search: assert property (@(posedge clk) disable iff (!rst_n)
		s.cal_state == csric_pkg::CAL_BAND && !band_ok && s.vco_band != csric_pkg::BAND_MAX
		|=> s.vco_band == $past(s.vco_band) + 4'h1)
		else $error("Band search did not advance.");

	// The halt ends together with the completion event, which is then flagged.
	a_cal_halt_end: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(system_clock_halt) |-> s.cal_done_ev ##1 s.irq_flags[csric_pkg::IRQ_CAL_DONE_BIT])
		else $error("Halt ended without calibration completion.");

	// Control bits are zero right after reset.
	a_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
		$past(!rst_n) |-> s.cs_active == 2'b00 && s.cs_buffer == 2'b00 && !system_clock_halt)
		else $error("Calibrate or sync bit not zero after reset.");

	// A reset function write gives one pulse of the written bits.
	a_rf_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
		s_rf_write |=> s_rf_one_shot($past(s.w_data & csric_pkg::RF_MASK)))
		else $error("Reset function pulse wrong or not self clearing.");

	// Reset-all leaves only flags newly set in that cycle.
	a_clear_all: assert property (@(posedge clk) disable iff (!rst_n)
		s.rf_pulse[csric_pkg::RF_ALL_IRQ_BIT] |=> (s.irq_flags & ~$past(set_ev)) == 8'h00)
		else $error("Reset-all did not clear the interrupt flags.");

	// A watchdog reset restarts the count and suppresses the timeout.
	a_wdog_restart: assert property (@(posedge clk) disable iff (!rst_n)
		s.rf_pulse[csric_pkg::RF_WATCHDOG_BIT] |=> s.wdog_count == 32'h0000_0000 &&
		!watchdog_timeout)
		else $error("Watchdog reset did not restart cleanly.");

	// A clear bit drops its flag unless a new event arrives with it.
	a_irq_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clr_ev != 8'h00 |=> (s.irq_flags & $past(clr_ev & ~set_ev)) == 8'h00)
		else $error("Interrupt flag not cleared.");

	// An event wins over a clear in the same cycle.
	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		set_ev != 8'h00 |=> (s.irq_flags & $past(set_ev)) == $past(set_ev))
		else $error("Interrupt event lost against a clear.");

	// Reset function and interrupt clear registers read back as zero.
	a_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_fire && (is_reg(s_axi_req.araddr, csric_pkg::IDX_RESET_FN) ||
		is_reg(s_axi_req.araddr, csric_pkg::IDX_IRQ_CLEAR)) |=> s_axi_rsp.rdata == 32'h0000_0000)
		else $error("Self clearing register read back nonzero.");

	// Amplitude search steps by one while the detector rejects the level.
	a_amp_search: assert property (@(posedge clk) disable iff (!rst_n)
		s.cal_state == csric_pkg::CAL_AMP && !amp_ok && s.vco_amp != csric_pkg::AMP_MAX
		|=> s.vco_amp == $past(s.vco_amp) + 3'h1)
		else $error("Amplitude search did not advance.");

	// The resynchronization pulse appears only as the stall ends.
	a_sync_only_fall: assert property (@(posedge clk) disable iff (!rst_n)
		dist_sync_pulse |-> $fell(dist_stall))
		else $error("Sync pulse without the end of a stall.");

	// A launched calibration raises its start event and then its flag.
	a_cal_start_flag: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(system_clock_halt) |-> s_cal_started)
		else $error("Calibration start not flagged.");

	// A timeout never follows a watchdog reset and needs a nonzero period.
	a_wdog_timeout: assert property (@(posedge clk) disable iff (!rst_n)
		watchdog_timeout |-> !$past(s.rf_pulse[csric_pkg::RF_WATCHDOG_BIT]) &&
		$past(wdog_period) != 32'h0000_0000)
		else $error("Watchdog timeout after a reset or while disabled.");

	// A synchronised lock loss sets the unlocked flag next cycle.
	a_unlock_flag: assert property (@(posedge clk) disable iff (!rst_n)
		lock_fall |=> s.irq_flags[csric_pkg::IRQ_UNLOCKED_BIT])
		else $error("Unlocked flag not set after lock loss.");
endmodule

// ### tb/csric_regs_test.sv
// Self-checking testbench for the calibration, sync, reset and interrupt clear register block.
module csric_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         CAL_N = 40;                     // Shortened calibration length.
	localparam int         LIM   = 60;                     // Bound on each handshake wait.
	localparam logic [1:0] OK    = csric_pkg::RESP_OKAY;   // Expected normal response.
	localparam int         IRQB[4] = '{0, 1, 4, 5};        // Clearable flag positions.
	// Clock, reset and register bus.
	logic                         clk;
	logic                         rst_n;
	csric_pkg::csric_axi_req_type req;
	csric_pkg::csric_axi_rsp_type rsp;
	// PLL, lock and watchdog inputs.
	logic                         pll_enable, band_ok, amp_ok, lock_pin;
	logic [31:0]                  wdog_period;
	// Outputs of the block.
	logic                         halt, stall, sync_p, c_lf, c_cci, c_pa, r_as, r_tw, c_irq, wd_to;
	logic [3:0]                   band;
	logic [2:0]                   amp;
	logic [7:0]                   flags;
	// Pulse vector, pulse counters and bench bookkeeping.
	logic [7:0]                   pv;
	logic [7:0]                   exp;
	int                           pcnt[8] = '{default: 0};
	int                           snap[8];
	int                           halt_cnt = 0;
	int                           base;
	int                           bad_count = 0;
	int                           comparisons = 0;
	assign pv = {sync_p, c_lf, c_cci, c_pa, r_as, r_tw, c_irq, wd_to};
	// Block under test, with a calibration short enough for simulation.
	csric_regs #(.CAL_CYCLES(CAL_N)) csric_regs_inst (
		.clk(clk), .rst_n(rst_n), .s_axi_req(req), .s_axi_rsp(rsp),
		.pll_enable(pll_enable), .band_ok(band_ok), .amp_ok(amp_ok), .pll_locked_pin(lock_pin),
		.system_clock_halt(halt), .vco_band(band), .vco_amp(amp),
		.dist_stall(stall), .dist_sync_pulse(sync_p),
		.clear_loop_filter(c_lf), .clear_comb_integrator_filter(c_cci),
		.clear_phase_accumulator(c_pa), .reset_auto_sync(r_as),
		.reset_tuning_word_history(r_tw), .clear_all_irqs(c_irq),
		.wdog_period(wdog_period), .watchdog_timeout(wd_to), .system_clock_irq_flags(flags));
	// The 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Counts pulses and halt cycles on the falling edge, where outputs are settled.
	always @(negedge clk) begin
		for (int i = 0; i < 8; i++) pcnt[i] += int'(pv[i]);
		halt_cnt += int'(halt);
	end
	// Byte address of a register index.
	function automatic logic [15:0] ba(input logic [13:0] i);
		return {i, 2'b00};
	endfunction
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Compares a seen value with the expected one and reports a difference.
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, want, seen);
		end
	endtask
	// A wait that ran out counts as a mismatch and closes the run.
	task automatic timeout_end();
		bad_count++;
		$display("BAD handshake expected answer seen none");
		summarize();
	endtask
	// One bus write; address and data are offered together and each released when taken.
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		{req.awvalid, req.wvalid, req.bready} <= 3'b111;
		{req.awaddr, req.wdata, req.wstrb} <= {a, 24'h0, d, 4'hF};
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < LIM);
		req.bready <= 1'b0;
		check("bresp", rsp.bresp, er);
		if (n >= LIM) timeout_end();
	endtask
	// One bus read; the data byte is compared only on a normal response.
	task automatic rd(input logic [15:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk);
		{req.arvalid, req.rready} <= 2'b11;
		req.araddr <= a;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < LIM);
		req.rready <= 1'b0;
		check("rresp", rsp.rresp, er);
		if (er === OK) check("rdata", rsp.rdata, {24'h0, ed});
		if (n >= LIM) timeout_end();
	endtask
	// Lets some cycles pass and stops at a falling edge.
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// Writes the calibration and sync byte, then commits it with a transfer.
	task automatic commit(input logic [7:0] d);
		wr(ba(csric_pkg::IDX_CAL_SYNC), d, OK);
		wr(ba(csric_pkg::IDX_TRANSFER), 8'h01, OK);
	endtask
	// Moves the lock pin and waits past its synchronizer.
	task automatic lock(input logic v);
		@(posedge clk);
		lock_pin <= v;
		wait_n(6);
	endtask
	// Main sequence.
	initial begin
		req = '0;
		wdog_period = '0;
		{rst_n, pll_enable, band_ok, amp_ok, lock_pin} = 5'b01000;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, then an unmapped address is refused.
		rd(ba(csric_pkg::IDX_CAL_SYNC), 8'h00, OK);
		check("stall", stall, 1'b0);
		wr(16'h0100, 8'h01, csric_pkg::RESP_DECERR);
		rd(16'h0100, 8'h00, csric_pkg::RESP_DECERR);
		// Sync bit: buffered until a transfer, stalls while set, pulses on release.
		wr(ba(csric_pkg::IDX_CAL_SYNC), 8'h02, OK);
		wait_n(2);
		check("stall", stall, 1'b0);
		rd(ba(csric_pkg::IDX_CAL_SYNC), 8'h02, OK);
		wr(ba(csric_pkg::IDX_TRANSFER), 8'h01, OK);
		wait_n(2);
		check("stall", stall, 1'b1);
		base = pcnt[7];
		commit(8'h00);
		wait_n(2);
		check("stall", stall, 1'b0);
		check("sync pulses", pcnt[7] - base, 1);
		// Calibration only on a committed rise with the PLL enabled.
		// The last run has both comparators satisfied at once, so each search stops early.
		for (int s = 0; s < 6; s++) begin
			@(posedge clk);
			pll_enable <= (s != 3);
			{band_ok, amp_ok} <= {2{s == 5}};
			base = halt_cnt;
			commit((s == 2 || s == 4) ? 8'h00 : 8'h01);
			if (s == 0) rd(ba(csric_pkg::IDX_STATUS), 8'h01, OK);
			wait_n(CAL_N + 8);
			check("halt cycles", halt_cnt - base, (s == 0 || s == 5) ? CAL_N : 0);
			if (s == 0) rd(ba(csric_pkg::IDX_TUNING), 8'h7F, OK);
		end
		check("band", band, 4'h0);
		check("amp", amp, 3'h0);
		// Lock flags, then each clear bit takes away only its own flag.
		lock(1'b1);
		lock(1'b0);
		check("flags", flags, 8'h33);
		rd(ba(csric_pkg::IDX_IRQ_FLAGS), 8'h33, OK);
		exp = 8'h33;
		foreach (IRQB[k]) begin
			wr(ba(csric_pkg::IDX_IRQ_CLEAR), 8'(1 << IRQB[k]), OK);
			exp[IRQB[k]] = 1'b0;
			wait_n(2);
			check("flags", flags, exp);
		end
		rd(ba(csric_pkg::IDX_IRQ_CLEAR), 8'h00, OK);
		rd(ba(csric_pkg::IDX_TRANSFER), 8'h00, OK);
		// Reset function bits 1 to 6 each give exactly one pulse on their own output.
		lock(1'b1);
		rd(ba(csric_pkg::IDX_STATUS), 8'h04, OK);
		for (int i = 1; i < 7; i++) begin
			snap = pcnt;
			wr(ba(csric_pkg::IDX_RESET_FN), 8'(1 << i), OK);
			wait_n(3);
			for (int j = 1; j < 7; j++) begin
				check("pulse", pcnt[j] - snap[j], (i == j) ? 1 : 0);
			end
		end
		check("flags", flags, 8'h00);
		rd(ba(csric_pkg::IDX_RESET_FN), 8'h00, OK);
		// Frequent watchdog resets hold off the timeout; then it runs freely.
		@(posedge clk);
		wdog_period <= 32'd30;
		wr(ba(csric_pkg::IDX_RESET_FN), 8'h01, OK);
		base = pcnt[0];
		for (int i = 0; i < 20; i++) wr(ba(csric_pkg::IDX_RESET_FN), 8'h01, OK);
		check("timeouts", pcnt[0] - base, 0);
		base = pcnt[0];
		wait_n(95);
		check("timeouts", pcnt[0] - base, 3);
		summarize();
	end
endmodule
